// [shared/gpio_pkg.sv]
// shared constants and carrier types for the dual gpio port block
package gpio_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NARROW_PINS = 5;
	localparam int WIDE_PINS = 8;

	// register byte addresses
	localparam logic [15:0] NARROW_OUT_LATCH_ADDR = 16'h0005;
	localparam logic [15:0] WIDE_OUT_LATCH_ADDR = 16'h0007;
	localparam logic [15:0] NARROW_PIN_INPUT_ADDR = 16'h0012;
	localparam logic [15:0] WIDE_PIN_INPUT_ADDR = 16'h0014;
	localparam logic [15:0] NARROW_DIRECTION_ADDR = 16'h0f1f;
	localparam logic [15:0] WIDE_DIRECTION_ADDR = 16'h0f21;
	localparam logic [15:0] NARROW_FUNC_SEL_ADDR = 16'h0f39;
	localparam logic [15:0] WIDE_FUNC_SEL_ADDR = 16'h0f3b;

	// reset values and unmapped read value
	localparam logic [7:0] OUT_LATCH_RST = 8'h00;
	localparam logic [7:0] DIRECTION_RST = 8'h00;
	localparam logic [7:0] FUNC_SEL_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// wide port function-select writable field
	localparam logic [7:0] WIDE_FUNC_SEL_MASK = 8'h1f;

	// wide port bit positions
	localparam int WIDE_IRQ_LSB = 5;
	localparam int WIDE_DIV_BIT = 4;
	localparam int WIDE_TIMER_A_LSB = 2;
	localparam int WIDE_TIMER_LSB = 0;

	// peripheral outputs that may be routed onto wide port pins
	typedef struct packed {
		logic       divider;       // divider_out_pin source
		logic [1:0] pulse_a;       // pulse_gen_a_out_one/zero
		logic [1:0] pulse;         // pulse_out_ch1/ch0
		logic [1:0] width_mod;     // width_mod_out_ch1/ch0
		logic [1:0] width_mod_sel; // 1 selects width_mod over pulse per channel
	} periph_out_t;

	// pin levels handed to on-chip peripherals from the wide port
	typedef struct packed {
		logic [2:0] ext_irq;   // ext_irq_line_four..two
		logic [1:0] timer_a_in; // timer_a_in_one/zero
		logic [1:0] timer_in;  // timer_in_ch1/ch0
	} periph_in_t;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;
endpackage

// [hw/pin_sync.sv]
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk, // system clock
	input  wire logic             rst,      // async reset, active high
	input  wire logic             ce,       // clock enable
	input  wire logic [WIDTH-1:0] pin_lvl,  // raw pin levels
	output logic      [WIDTH-1:0] lvl_q     // filtered levels
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] lvl_d;

	// stage one is read only by stage two, so metastability never reaches the filter
	assign agree = ~(s2_q ^ s3_q);
	assign lvl_d = (agree & s3_q) | (~agree & lvl_q);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end
		else if (ce)
		begin
			s1_q <= pin_lvl;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end
endmodule

// [hw/dual_gpio_port.sv]
// five-pin analog-shared port and eight-pin timer-shared port with register access
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module dual_gpio_port (
	input  wire logic                     core_clk,            // system clock, 25 MHz
	input  wire logic                     rst,                 // async reset, active high
	input  wire logic                     ce,                  // clock enable, freezes all state when low
	input  wire gpio_pkg::bus_req_t       bus_req,             // register bus request
	output logic      [7:0]               rdata_q,             // read data, valid the cycle after rd
	input  wire logic [4:0]               narrow_pin_in,       // narrow pin levels
	output logic      [4:0]               narrow_pin_out_q,    // narrow pin drive value
	output logic      [4:0]               narrow_pin_oe_n_q,   // narrow pin enable, low drives
	output logic      [4:0]               narrow_analog_en_q,  // analog_channel_eight..twelve connect
	input  wire logic [7:0]               wide_pin_in,         // wide pin levels
	output logic      [7:0]               wide_pin_out_q,      // wide pin drive value
	output logic      [7:0]               wide_pin_oe_n_q,     // wide pin enable, low drives
	input  wire gpio_pkg::periph_out_t    periph_out,          // peripheral outputs for wide pins
	output gpio_pkg::periph_in_t          periph_in_q          // wide pin levels to peripherals
);
	logic [7:0] n_latch_q;
	logic [7:0] n_dir_q;
	logic [7:0] n_fc_q;
	logic [7:0] w_latch_q;
	logic [7:0] w_dir_q;
	logic [7:0] w_fc_q;
	logic [4:0] n_lvl;
	logic [7:0] w_lvl;

	// read gate shared by both ports
	function automatic logic [7:0] port_read(input logic [7:0] lvl, input logic [7:0] dir,
		input logic [7:0] fc);
		port_read = lvl & ~dir & ~fc;
	endfunction

	// drive value: peripheral output only when output mode and select are both set
	function automatic logic [7:0] pin_drive(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] fc, input logic [7:0] alt);
		pin_drive = ((dir & fc) & alt) | (~(dir & fc) & latch);
	endfunction

	pin_sync #(
		.WIDTH (5)
	) u_narrow_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.pin_lvl  (narrow_pin_in),
		.lvl_q    (n_lvl)
	);

	pin_sync #(
		.WIDTH (8)
	) u_wide_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.pin_lvl  (wide_pin_in),
		.lvl_q    (w_lvl)
	);

	// register decode
	wire        wr_en = bus_req.wr && ce;
	wire        rd_en = bus_req.rd && ce;
	wire        sel_n_latch = bus_req.addr == gpio_pkg::NARROW_OUT_LATCH_ADDR;
	wire        sel_w_latch = bus_req.addr == gpio_pkg::WIDE_OUT_LATCH_ADDR;
	wire        sel_n_pin = bus_req.addr == gpio_pkg::NARROW_PIN_INPUT_ADDR;
	wire        sel_w_pin = bus_req.addr == gpio_pkg::WIDE_PIN_INPUT_ADDR;
	wire        sel_n_dir = bus_req.addr == gpio_pkg::NARROW_DIRECTION_ADDR;
	wire        sel_w_dir = bus_req.addr == gpio_pkg::WIDE_DIRECTION_ADDR;
	wire        sel_n_fc = bus_req.addr == gpio_pkg::NARROW_FUNC_SEL_ADDR;
	wire        sel_w_fc = bus_req.addr == gpio_pkg::WIDE_FUNC_SEL_ADDR;

	// pin input views; upper narrow bits read zero
	wire [7:0]  n_pin_view = port_read({3'h0, n_lvl}, n_dir_q, n_fc_q);
	wire [7:0]  w_pin_view = port_read(w_lvl, w_dir_q, 8'h00);

	wire [7:0]  rd_mux =
		sel_n_latch ? n_latch_q :
		sel_w_latch ? w_latch_q :
		sel_n_pin   ? n_pin_view :
		sel_w_pin   ? w_pin_view :
		sel_n_dir   ? n_dir_q :
		sel_w_dir   ? w_dir_q :
		sel_n_fc    ? n_fc_q :
		sel_w_fc    ? w_fc_q :
		gpio_pkg::UNMAPPED_READ;

	// secondary outputs in wide bit order: bit 4 divider, 3..2 pulse a, 1..0 pulse or pwm
	wire [1:0]  pwm_or_pulse = (periph_out.width_mod_sel & periph_out.width_mod) |
		(~periph_out.width_mod_sel & periph_out.pulse);
	wire [7:0]  w_alt = {3'h0, periph_out.divider, periph_out.pulse_a, pwm_or_pulse};

	// narrow pins only ever carry the latch; the analog path is a separate switch
	wire [7:0]  n_drive = pin_drive(n_latch_q, n_dir_q, 8'h00, 8'h00);
	wire [7:0]  w_drive = pin_drive(w_latch_q, w_dir_q, w_fc_q, w_alt);

	// peripheral inputs see the pin only while the bit is an input
	wire [7:0]  w_in_view = w_lvl & ~w_dir_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			n_latch_q <= gpio_pkg::OUT_LATCH_RST;
			n_dir_q <= gpio_pkg::DIRECTION_RST;
			n_fc_q <= gpio_pkg::FUNC_SEL_RST;
		end
		else if (wr_en)
		begin
			if (sel_n_latch)
				n_latch_q <= bus_req.wdata;
			if (sel_n_dir)
				n_dir_q <= bus_req.wdata;
			if (sel_n_fc)
				n_fc_q <= bus_req.wdata;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			w_latch_q <= gpio_pkg::OUT_LATCH_RST;
			w_dir_q <= gpio_pkg::DIRECTION_RST;
			w_fc_q <= gpio_pkg::FUNC_SEL_RST;
		end
		else if (wr_en)
		begin
			if (sel_w_latch)
				w_latch_q <= bus_req.wdata;
			if (sel_w_dir)
				w_dir_q <= bus_req.wdata;
			if (sel_w_fc)
				w_fc_q <= bus_req.wdata & gpio_pkg::WIDE_FUNC_SEL_MASK;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdata_q <= '0;
		else if (rd_en)
			rdata_q <= rd_mux;
	end

	// pin drivers are registered so the pads never see decode glitches
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			narrow_pin_out_q <= '0;
			narrow_pin_oe_n_q <= '1;
			narrow_analog_en_q <= '0;
			wide_pin_out_q <= '0;
			wide_pin_oe_n_q <= '1;
			periph_in_q <= '0;
		end
		else if (ce)
		begin
			narrow_pin_out_q <= n_drive[4:0];
			narrow_pin_oe_n_q <= ~n_dir_q[4:0];
			narrow_analog_en_q <= n_fc_q[4:0];
			wide_pin_out_q <= w_drive;
			wide_pin_oe_n_q <= ~w_dir_q;
			periph_in_q.ext_irq <= w_in_view[7:5];
			periph_in_q.timer_a_in <= w_in_view[3:2];
			periph_in_q.timer_in <= w_in_view[1:0];
		end
	end

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_rd(logic sel);
		rd_en && sel;
	endsequence

	sequence s_wr(logic sel);
		wr_en && sel;
	endsequence

	a_narrow_latch_write: assert property (s_wr(sel_n_latch) |=> n_latch_q == $past(bus_req.wdata))
		else $error("narrow latch did not take the written value");

	a_narrow_drive_level: assert property (ce |=>
		narrow_pin_out_q == $past(n_latch_q[4:0]))
		else $error("narrow pin does not follow the latch");

	a_narrow_oe_dir: assert property (ce |=> narrow_pin_oe_n_q == ~$past(n_dir_q[4:0]))
		else $error("narrow pin enable does not follow direction");

	a_narrow_analog_sel: assert property (s_wr(sel_n_fc) ##1 ce |=>
		narrow_analog_en_q == $past(n_fc_q[4:0]))
		else $error("analog connect does not follow function select");

	a_narrow_read_gate: assert property (s_rd(sel_n_pin) |=>
		(rdata_q & ($past(n_dir_q) | $past(n_fc_q) | 8'he0)) == 8'h00)
		else $error("narrow pin read not gated to zero");

	a_narrow_read_level: assert property (s_rd(sel_n_pin) && n_dir_q[4:0] == 5'h00 && n_fc_q[4:0] == 5'h00 |=>
		rdata_q == {3'h0, $past(n_lvl)})
		else $error("narrow pin read lost the pin level");

	a_wide_read_gate: assert property (s_rd(sel_w_pin) |=>
		rdata_q == ($past(w_lvl) & ~$past(w_dir_q)))
		else $error("wide pin read does not follow direction");

	a_wide_fc_upper: assert property (s_wr(sel_w_fc) |=> w_fc_q[7:5] == 3'h0)
		else $error("wide select upper bits not zero");

	a_wide_div_route: assert property (ce |=> wide_pin_out_q[4] ==
		($past(w_dir_q[4] & w_fc_q[4]) ? $past(periph_out.divider) : $past(w_latch_q[4])))
		else $error("divider output not routed to pin four");

	a_wide_irq_gate: assert property (ce |=> periph_in_q.ext_irq == ($past(w_lvl[7:5]) & ~$past(w_dir_q[7:5])))
		else $error("interrupt inputs not gated by direction");

	a_unmapped_read: assert property (s_rd(!(sel_n_latch || sel_w_latch || sel_n_pin || sel_w_pin ||
		sel_n_dir || sel_w_dir || sel_n_fc || sel_w_fc)) |=> rdata_q == 8'h00)
		else $error("unmapped read not zero");

	a_frozen_ce: assert property (!ce |=> $stable(wide_pin_out_q) && $stable(rdata_q))
		else $error("state moved while clock enable low");

	// five enabled edges cover the three stages plus the filter register
	sequence s_ce_run;
		ce [*5];
	endsequence

	a_narrow_dir_write: assert property (s_wr(sel_n_dir) |=>
		n_dir_q == $past(bus_req.wdata))
		else $error("narrow direction did not take the written value");

	a_narrow_fc_write: assert property (s_wr(sel_n_fc) |=>
		n_fc_q == $past(bus_req.wdata))
		else $error("narrow select did not take the written value");

	a_wide_latch_write: assert property (s_wr(sel_w_latch) |=>
		w_latch_q == $past(bus_req.wdata))
		else $error("wide latch did not take the written value");

	a_wide_dir_write: assert property (s_wr(sel_w_dir) |=>
		w_dir_q == $past(bus_req.wdata))
		else $error("wide direction did not take the written value");

	a_wide_fc_write: assert property (s_wr(sel_w_fc) |=>
		w_fc_q[4:0] == $past(bus_req.wdata[4:0]))
		else $error("wide select did not take the written value");

	a_narrow_latch_read: assert property (s_rd(sel_n_latch) |=>
		rdata_q == $past(n_latch_q))
		else $error("narrow latch read back wrong");

	a_narrow_dir_read: assert property (s_rd(sel_n_dir) |=>
		rdata_q == $past(n_dir_q))
		else $error("narrow direction read back wrong");

	a_narrow_fc_read: assert property (s_rd(sel_n_fc) |=>
		rdata_q == $past(n_fc_q))
		else $error("narrow select read back wrong");

	a_wide_latch_read: assert property (s_rd(sel_w_latch) |=>
		rdata_q == $past(w_latch_q))
		else $error("wide latch read back wrong");

	a_wide_dir_read: assert property (s_rd(sel_w_dir) |=>
		rdata_q == $past(w_dir_q))
		else $error("wide direction read back wrong");

	a_wide_fc_read: assert property (s_rd(sel_w_fc) |=>
		rdata_q[7:5] == 3'h0 && rdata_q[4:0] == $past(w_fc_q[4:0]))
		else $error("wide select read back wrong");

	a_narrow_upper_zero: assert property (s_rd(sel_n_pin) |=>
		rdata_q[7:5] == 3'h0)
		else $error("narrow pin read upper bits not zero");

	a_wide_oe_dir: assert property (ce |=>
		wide_pin_oe_n_q == ~$past(w_dir_q))
		else $error("wide pin enable does not follow direction");

	a_wide_timer_gate: assert property (ce |=>
		periph_in_q.timer_in == ($past(w_lvl[1:0]) & ~$past(w_dir_q[1:0])))
		else $error("timer inputs not gated by direction");

	a_wide_timer_a_gate: assert property (ce |=>
		periph_in_q.timer_a_in == ($past(w_lvl[3:2]) & ~$past(w_dir_q[3:2])))
		else $error("timer a inputs not gated by direction");

	a_wide_upper_drive: assert property (ce |=>
		wide_pin_out_q[7:5] == $past(w_latch_q[7:5]))
		else $error("wide upper pins do not follow the latch");

	a_wide_latch_route: assert property (ce && (w_dir_q[3:0] & w_fc_q[3:0]) == 4'h0 |=>
		wide_pin_out_q[3:0] == $past(w_latch_q[3:0]))
		else $error("wide low pins do not follow the latch");

	a_wide_pulse_route: assert property (ce && (w_dir_q[3:2] & w_fc_q[3:2]) == 2'h3 |=>
		wide_pin_out_q[3:2] == $past(periph_out.pulse_a))
		else $error("pulse a outputs not routed");

	a_wide_pwm_route: assert property (ce && w_dir_q[0] && w_fc_q[0] && periph_out.width_mod_sel[0] |=>
		wide_pin_out_q[0] == $past(periph_out.width_mod[0]))
		else $error("width modulated output not routed to pin zero");

	a_wide_pulse_ch: assert property (ce && w_dir_q[1] && w_fc_q[1] && !periph_out.width_mod_sel[1] |=>
		wide_pin_out_q[1] == $past(periph_out.pulse[1]))
		else $error("pulse output not routed to pin one");

	a_read_data_hold: assert property (!rd_en |=>
		$stable(rdata_q))
		else $error("read data moved without a read");

	a_pin_write_ignored: assert property (s_wr(sel_n_pin || sel_w_pin) |=>
		$stable({n_latch_q, n_dir_q, n_fc_q, w_latch_q, w_dir_q, w_fc_q}))
		else $error("write to a pin input address changed a register");

	a_wide_sync_accept: assert property (s_ce_run ##0 $changed(w_lvl) |->
		w_lvl == $past(wide_pin_in, 4) && w_lvl == $past(wide_pin_in, 3))
		else $error("wide pin level accepted before two stages agreed");

	a_narrow_sync_accept: assert property (s_ce_run ##0 $changed(n_lvl) |->
		n_lvl == $past(narrow_pin_in, 4) && n_lvl == $past(narrow_pin_in, 3))
		else $error("narrow pin level accepted before two stages agreed");

	a_frozen_regs: assert property (!ce |=>
		$stable({n_latch_q, n_dir_q, n_fc_q, w_latch_q, w_dir_q, w_fc_q}) && $stable(w_lvl))
		else $error("register moved while clock enable low");
endmodule

// [verification/gpio_board_model.sv]
// board-side model: resolves each two-way pin from the block's drive and the board's own level
`timescale 1ns/100ps
module gpio_board_model (
	input  wire logic [4:0] narrow_out,   // block drive value
	input  wire logic [4:0] narrow_oe_n,  // block enable, low drives
	input  wire logic [4:0] narrow_board, // level the board puts on undriven pins
	input  wire logic [7:0] wide_out,     // block drive value
	input  wire logic [7:0] wide_oe_n,    // block enable, low drives
	input  wire logic [7:0] wide_board,   // level the board puts on undriven pins
	output logic      [4:0] narrow_lvl,   // resolved narrow pin level
	output logic      [7:0] wide_lvl      // resolved wide pin level
);
	// the board never fights the block: where the block drives, the wire follows it
	assign narrow_lvl = (~narrow_oe_n & narrow_out) | (narrow_oe_n & narrow_board);
	assign wide_lvl = (~wide_oe_n & wide_out) | (wide_oe_n & wide_board);
endmodule

// [verification/dual_gpio_port_bench.sv]
// self-checking bench for the dual gpio port block
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module dual_gpio_port_bench;
	logic                  core_clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  ce = 1'b1;
	gpio_pkg::bus_req_t    bus_req = '0;
	gpio_pkg::periph_out_t periph_out = '0;
	gpio_pkg::periph_in_t  periph_in_q;
	logic [7:0]            rdata_q;
	logic [4:0]            narrow_pin_in;
	logic [4:0]            narrow_pin_out_q;
	logic [4:0]            narrow_pin_oe_n_q;
	logic [4:0]            narrow_analog_en_q;
	logic [7:0]            wide_pin_in;
	logic [7:0]            wide_pin_out_q;
	logic [7:0]            wide_pin_oe_n_q;
	logic [4:0]            narrow_board = 5'h15;
	logic [7:0]            wide_board = 8'ha5;
	int                    mismatches = 0;
	int                    compares = 0;
	int                    cycles = 0;
	localparam logic [15:0] RW_ADDR [6] = '{gpio_pkg::NARROW_OUT_LATCH_ADDR, gpio_pkg::WIDE_OUT_LATCH_ADDR,
		gpio_pkg::NARROW_DIRECTION_ADDR, gpio_pkg::WIDE_DIRECTION_ADDR,
		gpio_pkg::NARROW_FUNC_SEL_ADDR, gpio_pkg::WIDE_FUNC_SEL_ADDR};

	always #20 core_clk = ~core_clk;

	dual_gpio_port dut (
		.core_clk           (core_clk),
		.rst                (rst),
		.ce                 (ce),
		.bus_req            (bus_req),
		.rdata_q            (rdata_q),
		.narrow_pin_in      (narrow_pin_in),
		.narrow_pin_out_q   (narrow_pin_out_q),
		.narrow_pin_oe_n_q  (narrow_pin_oe_n_q),
		.narrow_analog_en_q (narrow_analog_en_q),
		.wide_pin_in        (wide_pin_in),
		.wide_pin_out_q     (wide_pin_out_q),
		.wide_pin_oe_n_q    (wide_pin_oe_n_q),
		.periph_out         (periph_out),
		.periph_in_q        (periph_in_q)
	);

	gpio_board_model board (
		.narrow_out   (narrow_pin_out_q),
		.narrow_oe_n  (narrow_pin_oe_n_q),
		.narrow_board (narrow_board),
		.wide_out     (wide_pin_out_q),
		.wide_oe_n    (wide_pin_oe_n_q),
		.wide_board   (wide_board),
		.narrow_lvl   (narrow_pin_in),
		.wide_lvl     (wide_pin_in)
	);

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// a leading edge keeps two back-to-back calls from assigning the request in one time step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= {a, d, 2'b10};
		@(posedge core_clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_req <= {a, 8'h00, 2'b01};
		@(posedge core_clk);
		bus_req <= '0;
		#1;
		`CHK(rdata_q, exp)
	endtask

	// pin changes need four edges through the synchroniser, so eight leaves margin
	task automatic settle;
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		foreach (RW_ADDR[i]) rd(RW_ADDR[i], 8'h00);
		rd(16'h0006, gpio_pkg::UNMAPPED_READ);
		settle();
		rd(gpio_pkg::NARROW_PIN_INPUT_ADDR, 8'h15);
		rd(gpio_pkg::WIDE_PIN_INPUT_ADDR, 8'ha5);
		`CHK(periph_in_q, 7'b101_01_01)
		wr(gpio_pkg::NARROW_DIRECTION_ADDR, 8'he0);
		wr(gpio_pkg::NARROW_FUNC_SEL_ADDR, 8'h03);
		settle();
		`CHK(narrow_analog_en_q, 5'h03)
		rd(gpio_pkg::NARROW_PIN_INPUT_ADDR, 8'h14);
		rd(gpio_pkg::NARROW_DIRECTION_ADDR, 8'he0);
		wr(gpio_pkg::NARROW_DIRECTION_ADDR, 8'he4);
		wr(gpio_pkg::NARROW_OUT_LATCH_ADDR, 8'h1b);
		settle();
		`CHK(narrow_pin_out_q, 5'h1b)
		`CHK(narrow_pin_oe_n_q, 5'h1b)
		rd(gpio_pkg::NARROW_PIN_INPUT_ADDR, 8'h10);
		wr(gpio_pkg::WIDE_DIRECTION_ADDR, 8'hff);
		wr(gpio_pkg::WIDE_OUT_LATCH_ADDR, 8'h5a);
		settle();
		`CHK(wide_pin_out_q, 8'h5a)
		`CHK(wide_pin_oe_n_q, 8'h00)
		`CHK(periph_in_q, 7'b000_00_00)
		rd(gpio_pkg::WIDE_PIN_INPUT_ADDR, 8'h00);
		@(posedge core_clk);
		periph_out <= '{divider: 1'b1, pulse_a: 2'b01, pulse: 2'b10, width_mod: 2'b01, width_mod_sel: 2'b01};
		wr(gpio_pkg::WIDE_FUNC_SEL_ADDR, 8'hff);
		rd(gpio_pkg::WIDE_FUNC_SEL_ADDR, 8'h1f);
		settle();
		`CHK(wide_pin_out_q, 8'h57)
		wr(gpio_pkg::WIDE_PIN_INPUT_ADDR, 8'hff);
		wr(16'h0006, 8'hff);
		wr(gpio_pkg::WIDE_DIRECTION_ADDR, 8'h00);
		settle();
		rd(gpio_pkg::WIDE_PIN_INPUT_ADDR, 8'ha5);
		`CHK(periph_in_q, 7'b101_01_01)
		rd(16'h0006, gpio_pkg::UNMAPPED_READ);
		rd(gpio_pkg::WIDE_OUT_LATCH_ADDR, 8'h5a);
		// a write while the enable is low must be ignored
		@(posedge core_clk);
		ce <= 1'b0;
		wr(gpio_pkg::NARROW_OUT_LATCH_ADDR, 8'h00);
		ce <= 1'b1;
		rd(gpio_pkg::NARROW_OUT_LATCH_ADDR, 8'h1b);
		end_of_test();
	end
endmodule
